// File: src/dbgc_pkg.sv
// shared constants and carrier types for the serial debug controller
package dbgc_pkg;
  // debug status/control bit positions
  localparam int SC_ENABLE_BIT = 7;
  localparam int SC_ACTIVE_BIT = 6;
  localparam int SC_BKEN_BIT   = 5;
  localparam int SC_TYPE_BIT   = 4;
  localparam int SC_CLK_BIT    = 3;
  localparam int SC_WS_BIT     = 2;
  localparam int SC_WSF_BIT    = 1;
  localparam int SC_DVF_BIT    = 0;
  // reset values
  localparam logic [7:0]  SC_RESET     = 8'h00;
  localparam logic [15:0] BKPT_RESET   = 16'h0000;
  localparam logic [15:0] RSP_RESET    = 16'h0000;
  // force-reset register
  localparam int          FRC_BIT      = 0;
  localparam logic [7:0]  FRC_RD_VALUE = 8'h00;
  // serial debug command codes
  localparam logic [7:0]  CMD_READ_STATUS   = 8'hE4;
  localparam logic [7:0]  CMD_WRITE_CONTROL = 8'hC4;
  localparam logic [7:0]  CMD_BREAKPOINT_READ_CMD     = 8'hE2;
  localparam logic [7:0]  CMD_BREAKPOINT_WRITE_CMD    = 8'hC2;
  localparam logic [7:0]  CMD_HALT          = 8'h90;
  localparam logic [7:0]  CMD_GO            = 8'h08;

  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic [15:0] data;
  } dbgc_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } dbgc_rsp_t;

  typedef struct packed {
    logic        addr_valid;
    logic        opcode_fetch;
    logic        insn_boundary;
    logic        tag_at_end;
    logic        wait_stop;
    logic [15:0] addr;
  } dbgc_cpu_t;

  typedef struct packed {
    logic       frc_wr;
    logic       frc_rd;
    logic       from_debug;
    logic [7:0] wdata;
    logic       acc_start;
    logic       acc_fail_ws;
  } dbgc_mem_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT_STOP,
    ST_ACTIVE
  } dbgc_state_t;
endpackage : dbgc_pkg

// File: src/dbgc_flag.sv
// sticky flag where a set in the clear cycle wins
`timescale 1ns/1ps
module dbgc_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // events
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      flag_q
);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flag_q <= 1'b0;
    else if (set)
      flag_q <= 1'b1;
    else if (clr)
      flag_q <= 1'b0;
  end
endmodule : dbgc_flag

// File: src/dbgc_bkpt.sv
// breakpoint match address holder and address comparator
`timescale 1ns/1ps
module dbgc_bkpt (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register load
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] match_q,
  // cpu address bus
  input  wire logic        addr_valid,
  input  wire logic [15:0] addr,
  input  wire logic        enable,
  output logic             hit
);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      match_q <= dbgc_pkg::BKPT_RESET;
    else if (wr_en)
      match_q <= wr_data;
  end

  // disabled compare ignores the stored address entirely
  assign hit = enable && addr_valid && (addr == match_q);
endmodule : dbgc_bkpt

// File: src/dbgc_ctrl.sv
// serial debug controller: status/control, breakpoint, force reset
//
// What this block does
// - eight-bit debug status and control register
// - sixteen-bit breakpoint address register
// - registers reached only by debug commands
// - enable bit frozen while in active mode
// - status bits never written by control command
// - bit 7 gates active mode, reset clears
// - bit 6 shows active debug mode
// - bit 5 clear disables every breakpoint
// - type 1 match halts at instruction boundary
// - type 0 match tags opcode, halts at end
// - bit 3 selects communication clock, reset 0
// - bit 2 shows wait or stop history
// - halt command leaves wait or stop
// - bit 1 flags access lost to wait/stop
// - bit 0 never reports a failure
// - user writes ignored, reads return zero
// - debug write of bit 0 resets MCU
// - code E4 returns status register
// - code C4 loads writable control bits
// - code E2 returns breakpoint address
// - code C2 loads breakpoint address
`timescale 1ns/1ps
module dbgc_ctrl (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // decoded serial debug commands
  input  wire dbgc_pkg::dbgc_cmd_t cmd,
  output dbgc_pkg::dbgc_rsp_t      rsp_q,
  // serial memory path to the force-reset register
  input  wire dbgc_pkg::dbgc_mem_t mem,
  output logic [7:0]               frc_rdata_q,
  output logic                     frc_rvalid_q,
  output logic                     force_reset_q,
  // cpu side
  input  wire dbgc_pkg::dbgc_cpu_t cpu,
  output logic                     cpu_halt_q,
  output logic                     bkpt_tag_q,
  // communication clock choice
  output logic                     comm_clock_select_q
);
  dbgc_pkg::dbgc_state_t state_q;
  dbgc_pkg::dbgc_state_t state_d;
  logic        enable_q;
  logic        bken_q;
  logic        type_q;
  logic        ws_hold_q;
  logic        ws_bit;
  logic        wsf_q;
  logic        pend_q;
  logic        hit;
  logic [15:0] match_q;
  logic [7:0]  status;
  logic        is_rd_status;
  logic        is_wr_ctrl;
  logic        is_rd_bkpt;
  logic        is_wr_bkpt;
  logic        is_halt;
  logic        is_go;
  logic        enter_req;

  // command decode; no memory address reaches these registers
  assign is_rd_status = cmd.valid &&
                        cmd.code == dbgc_pkg::CMD_READ_STATUS;
  assign is_wr_ctrl   = cmd.valid &&
                        cmd.code == dbgc_pkg::CMD_WRITE_CONTROL;
  assign is_rd_bkpt   = cmd.valid &&
                        cmd.code == dbgc_pkg::CMD_BREAKPOINT_READ_CMD;
  assign is_wr_bkpt   = cmd.valid &&
                        cmd.code == dbgc_pkg::CMD_BREAKPOINT_WRITE_CMD;
  assign is_halt      = cmd.valid && cmd.code == dbgc_pkg::CMD_HALT;
  assign is_go        = cmd.valid && cmd.code == dbgc_pkg::CMD_GO;

  // status byte assembly
  always_comb
  begin
    status = dbgc_pkg::SC_RESET;
    status[dbgc_pkg::SC_ENABLE_BIT] = enable_q;
    status[dbgc_pkg::SC_ACTIVE_BIT] = cpu_halt_q;
    status[dbgc_pkg::SC_BKEN_BIT]   = bken_q;
    status[dbgc_pkg::SC_TYPE_BIT]   = type_q;
    status[dbgc_pkg::SC_CLK_BIT]    = comm_clock_select_q;
    status[dbgc_pkg::SC_WS_BIT]     = ws_bit;
    status[dbgc_pkg::SC_WSF_BIT]    = wsf_q;
    status[dbgc_pkg::SC_DVF_BIT]    = 1'b0;
  end

  // enable: reset or a control write with bit 7 clear clears it; frozen while halted
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      enable_q <= 1'b0;
    else if (is_wr_ctrl && state_q != dbgc_pkg::ST_ACTIVE)
      enable_q <= cmd.data[dbgc_pkg::SC_ENABLE_BIT];
  end

  // writable control bits; status bits are not in this path
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bken_q              <= 1'b0;
      type_q              <= 1'b0;
      comm_clock_select_q <= 1'b0;
    end
    else if (is_wr_ctrl)
    begin
      bken_q              <= cmd.data[dbgc_pkg::SC_BKEN_BIT];
      type_q              <= cmd.data[dbgc_pkg::SC_TYPE_BIT];
      comm_clock_select_q <= cmd.data[dbgc_pkg::SC_CLK_BIT];
    end
  end

  // breakpoint address register and compare
  dbgc_bkpt u_bkpt (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .wr_en      (is_wr_bkpt),
    .wr_data    (cmd.data),
    .match_q    (match_q),
    .addr_valid (cpu.addr_valid),
    .addr       (cpu.addr),
    .enable     (bken_q),
    .hit        (hit)
  );

  // forced breakpoint waits for the next instruction boundary
  dbgc_flag u_pend (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set     (hit && type_q),
    .clr     (!bken_q || cpu.insn_boundary ||
              state_q == dbgc_pkg::ST_ACTIVE),
    .flag_q  (pend_q)
  );

  // tagged breakpoint marks only the opcode being fetched
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bkpt_tag_q <= 1'b0;
    else
      bkpt_tag_q <= hit && !type_q && cpu.opcode_fetch;
  end

  // any cause of entry; nothing enters while enable is clear
  assign enter_req = enable_q &&
                     (is_halt ||
                      (pend_q && cpu.insn_boundary) ||
                      (bken_q && cpu.tag_at_end));

  // run / wait-stop / active sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      dbgc_pkg::ST_RUN:
      begin
        if (enter_req)
          state_d = dbgc_pkg::ST_ACTIVE;
        else if (cpu.wait_stop)
          state_d = dbgc_pkg::ST_WAIT_STOP;
      end
      dbgc_pkg::ST_WAIT_STOP:
      begin
        if (is_halt && enable_q)
          state_d = dbgc_pkg::ST_ACTIVE;
        else if (!cpu.wait_stop)
          state_d = dbgc_pkg::ST_RUN;
      end
      dbgc_pkg::ST_ACTIVE:
      begin
        if (is_go)
          state_d = dbgc_pkg::ST_RUN;
      end
      default:
        state_d = dbgc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q    <= dbgc_pkg::ST_RUN;
      cpu_halt_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cpu_halt_q <= state_d == dbgc_pkg::ST_ACTIVE;
    end
  end

  // remembers that active mode was reached from wait or stop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ws_hold_q <= 1'b0;
    else if (state_q == dbgc_pkg::ST_WAIT_STOP &&
             state_d == dbgc_pkg::ST_ACTIVE)
      ws_hold_q <= 1'b1;
    else if (state_d != dbgc_pkg::ST_ACTIVE)
      ws_hold_q <= 1'b0;
  end

  assign ws_bit = state_q == dbgc_pkg::ST_WAIT_STOP || ws_hold_q;

  // failure stays visible until the next access starts
  dbgc_flag u_wsf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set     (mem.acc_fail_ws),
    .clr     (mem.acc_start),
    .flag_q  (wsf_q)
  );

  // register read answers, one cycle after the command
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rsp_q <= '{valid: 1'b0, data: dbgc_pkg::RSP_RESET};
    else if (is_rd_status)
      rsp_q <= '{valid: 1'b1, data: {8'h00, status}};
    else if (is_rd_bkpt)
      rsp_q <= '{valid: 1'b1, data: match_q};
    else
      rsp_q <= '{valid: 1'b0, data: dbgc_pkg::RSP_RESET};
  end

  // force reset: only a debug-path write acts; reads see zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      force_reset_q <= 1'b0;
    else
      force_reset_q <= mem.frc_wr && mem.from_debug &&
                       mem.wdata[dbgc_pkg::FRC_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frc_rdata_q  <= dbgc_pkg::FRC_RD_VALUE;
      frc_rvalid_q <= 1'b0;
    end
    else
    begin
      frc_rdata_q  <= dbgc_pkg::FRC_RD_VALUE;
      frc_rvalid_q <= mem.frc_rd;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wait_then_halt;
    state_q == dbgc_pkg::ST_WAIT_STOP && is_halt && enable_q;
  endsequence

  sequence s_active_with_ws;
    cpu_halt_q && status[dbgc_pkg::SC_WS_BIT];
  endsequence

  enable_freeze_a: assert property (
    cpu_halt_q && state_q == dbgc_pkg::ST_ACTIVE && is_wr_ctrl
    |=> $stable(enable_q))
    else $error("enable changed while in active mode");

  status_ro_a: assert property (
    is_wr_ctrl && !mem.acc_fail_ws && !mem.acc_start
    && state_d == state_q && !cpu.wait_stop
    |=> $stable(wsf_q) && $stable(cpu_halt_q))
    else $error("control write altered a status bit");

  no_entry_off_a: assert property (
    !enable_q && state_q != dbgc_pkg::ST_ACTIVE |=> !cpu_halt_q)
    else $error("active mode entered while disabled");

  active_bit_a: assert property (
    status[dbgc_pkg::SC_ACTIVE_BIT] == (state_q == dbgc_pkg::ST_ACTIVE))
    else $error("active bit disagrees with state");

  bken_off_a: assert property (
    !bken_q |=> !bkpt_tag_q && !pend_q)
    else $error("breakpoint raised while disabled");

  forced_entry_a: assert property (
    state_q == dbgc_pkg::ST_RUN && enable_q && pend_q
    && cpu.insn_boundary |=> cpu_halt_q)
    else $error("forced breakpoint did not halt");

  tag_a: assert property (
    cpu.addr_valid && cpu.opcode_fetch && bken_q && !type_q
    && cpu.addr == match_q |=> bkpt_tag_q ##0 !pend_q)
    else $error("tagged breakpoint missed");

  clk_sel_a: assert property (
    is_wr_ctrl |=> comm_clock_select_q == $past(cmd.data[3]))
    else $error("clock select not loaded");

  ws_exit_a: assert property (
    s_wait_then_halt |=> s_active_with_ws)
    else $error("halt from wait/stop failed");

  ws_bit_a: assert property (
    state_q == dbgc_pkg::ST_RUN |-> !status[dbgc_pkg::SC_WS_BIT])
    else $error("wait/stop bit set while running");

  wsf_set_a: assert property (
    mem.acc_fail_ws |=> status[dbgc_pkg::SC_WSF_BIT])
    else $error("failure flag not set");

  dvf_zero_a: assert property (
    status[dbgc_pkg::SC_DVF_BIT] == 1'b0)
    else $error("data valid failure reported");

  user_frc_a: assert property (
    mem.frc_wr && !mem.from_debug |=> !force_reset_q)
    else $error("user write reset the part");

  frc_read_a: assert property (
    mem.frc_rd |=> frc_rvalid_q && frc_rdata_q == 8'h00)
    else $error("force-reset read not zero");

  dbg_frc_a: assert property (
    mem.frc_wr && mem.from_debug && mem.wdata[0]
    |=> force_reset_q ##1 !force_reset_q || mem.frc_wr)
    else $error("debug force reset missing");

  status_rsp_a: assert property (
    is_rd_status |=> rsp_q.valid && rsp_q.data[7:0] == $past(status))
    else $error("status read answered wrong");

  bkpt_rsp_a: assert property (
    is_rd_bkpt |=> rsp_q.valid && rsp_q.data == $past(match_q))
    else $error("breakpoint read answered wrong");

  bkpt_wr_a: assert property (
    is_wr_bkpt |=> match_q == $past(cmd.data))
    else $error("breakpoint write not stored");
endmodule : dbgc_ctrl

// File: bench/dbgc_host.sv
// debug host model: issues decoded commands and memory accesses
`timescale 1ns/1ps
module dbgc_host (
  // clock
  input  wire logic                clk,
  // device answers
  input  wire dbgc_pkg::dbgc_rsp_t rsp_q,
  // requests
  output dbgc_pkg::dbgc_cmd_t      cmd,
  output dbgc_pkg::dbgc_mem_t      mem
);
  initial
  begin
    cmd = '0;
    mem = '0;
  end

  // entered just after a rising edge; one command per call
  // an idle edge first, so the strobe never drops and rises in one step
  task automatic send(input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rd);
    @(posedge clk);
    #1;
    cmd = {1'b1, code, data};
    @(posedge clk);
    #1;
    rd = (rsp_q.valid === 1'b1) ? rsp_q.data : 16'hxxxx;
    cmd = '0;
  endtask : send

  // forcing a halt is only trusted once the active bit reads back set
  task automatic halt(output logic ok);
    logic [15:0] rd;
    send(dbgc_pkg::CMD_HALT, 16'h0000, rd);
    send(dbgc_pkg::CMD_READ_STATUS, 16'h0000, rd);
    ok = rd[dbgc_pkg::SC_ACTIVE_BIT];
  endtask : halt

  // f = {frc_wr, frc_rd, from_debug, wdata, acc_start, acc_fail_ws}
  task automatic mem_op(input logic [12:0] f);
    @(posedge clk);
    #1;
    mem = f;
    @(posedge clk);
    #1;
    mem = '0;
  endtask : mem_op
endmodule : dbgc_host

// File: bench/tb.sv
// self-checking bench for the serial debug controller
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] C_RS = 8'hE4;
  localparam logic [7:0] C_WC = 8'hC4;
  localparam logic [7:0] C_RB = 8'hE2;
  localparam logic [7:0] C_WB = 8'hC2;
  localparam logic [7:0] C_GO = 8'h08;
  localparam logic [7:0] C_HT = 8'h90;
  logic                clk;
  logic                sys_rst;
  dbgc_pkg::dbgc_cmd_t cmd;
  dbgc_pkg::dbgc_rsp_t rsp_q;
  dbgc_pkg::dbgc_mem_t mem;
  dbgc_pkg::dbgc_cpu_t cpu;
  logic [7:0]          frc_rdata_q;
  logic                frc_rvalid_q;
  logic                force_reset_q;
  logic                cpu_halt_q;
  logic                bkpt_tag_q;
  logic                comm_clock_select_q;
  logic [15:0]         rd;
  logic                ok;
  int                  n_errors = 0;
  int                  checks_done = 0;
  int                  cyc_cnt = 0;

  dbgc_ctrl dbgc_ctrl_inst (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .cmd                 (cmd),
    .rsp_q               (rsp_q),
    .mem                 (mem),
    .frc_rdata_q         (frc_rdata_q),
    .frc_rvalid_q        (frc_rvalid_q),
    .force_reset_q       (force_reset_q),
    .cpu                 (cpu),
    .cpu_halt_q          (cpu_halt_q),
    .bkpt_tag_q          (bkpt_tag_q),
    .comm_clock_select_q (comm_clock_select_q)
  );

  dbgc_host dbgc_host_inst (
    .clk   (clk),
    .rsp_q (rsp_q),
    .cmd   (cmd),
    .mem   (mem)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // the whole run is well under 200 cycles
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 2000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic cm(input logic [7:0] code, input logic [15:0] data);
    dbgc_host_inst.send(code, data, rd);
  endtask : cm

  task automatic st(input logic [7:0] exp);
    cm(C_RS, 16'h0000);
    chk("status", {8'h00, exp}, rd);
  endtask : st

  // f = {addr_valid, opcode_fetch, insn_boundary, tag_at_end}
  task automatic cpu_cyc(input logic [3:0] f, input logic [15:0] a);
    @(posedge clk);
    #1;
    cpu = {f, cpu.wait_stop, a};
    @(posedge clk);
    #1;
    cpu = {4'b0000, cpu.wait_stop, 16'h0000};
  endtask : cpu_cyc

  task automatic reset_dut();
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
  endtask : reset_dut

  initial
  begin
    cpu = '0;
    reset_dut();
    st(8'h00);
    chk("clock_sel", 16'h0000, comm_clock_select_q);
    cm(C_WB, 16'hA5C3);
    cm(C_RB, 16'h0000);
    chk("bkpt", 16'hA5C3, rd);
    cm(C_WC, 16'h00ff);
    st(8'hB8);
    chk("clock_sel", 16'h0001, comm_clock_select_q);
    $display("test registers done");
    dbgc_host_inst.halt(ok);
    chk("halt_ok", 16'h0001, ok);
    cm(C_WC, 16'h0030);
    st(8'hF0);
    cm(C_WB, 16'h1234);
    cm(C_GO, 16'h0000);
    st(8'hB0);
    cpu_cyc(4'b1000, 16'h1234);
    cpu_cyc(4'b0010, 16'h0000);
    chk("halt_out", 16'h0001, cpu_halt_q);
    cm(C_GO, 16'h0000);
    $display("test forced done");
    cm(C_WC, 16'h0080);
    cpu_cyc(4'b1100, 16'h1234);
    chk("tag", 16'h0000, bkpt_tag_q);
    cpu_cyc(4'b0011, 16'h0000);
    chk("halt_out", 16'h0000, cpu_halt_q);
    cm(C_WC, 16'h00A0);
    cpu_cyc(4'b1100, 16'h1234);
    chk("tag", 16'h0001, bkpt_tag_q);
    cpu_cyc(4'b0001, 16'h0000);
    chk("halt_out", 16'h0001, cpu_halt_q);
    cm(C_GO, 16'h0000);
    $display("test tagged done");
    cpu.wait_stop = 1'b1;
    cpu_cyc(4'b0000, 16'h0000);
    st(8'hA4);
    dbgc_host_inst.halt(ok);
    cpu.wait_stop = 1'b0;
    st(8'hE4);
    cm(C_GO, 16'h0000);
    st(8'hA0);
    $display("test wait_stop done");
    dbgc_host_inst.mem_op(13'h0402);
    dbgc_host_inst.mem_op(13'h0401);
    st(8'hA2);
    dbgc_host_inst.halt(ok);
    dbgc_host_inst.mem_op(13'h0402);
    st(8'hE0);
    cm(C_GO, 16'h0000);
    $display("test failure_flag done");
    dbgc_host_inst.mem_op(13'h1004);
    chk("force", 16'h0000, force_reset_q);
    dbgc_host_inst.mem_op(13'h0800);
    chk("frc_valid", 16'h0001, frc_rvalid_q);
    chk("frc_data", 16'h0000, frc_rdata_q);
    dbgc_host_inst.mem_op(13'h1404);
    chk("force", 16'h0001, force_reset_q);
    reset_dut();
    st(8'h00);
    cm(C_HT, 16'h0000);
    chk("halt_out", 16'h0000, cpu_halt_q);
    $display("test force_reset done");
    close_out();
  end
endmodule : tb
